//--- design/quhb_pkg.sv
// Constants shared by the quad UART host bus port and interrupt router
//
// Contract
// - Three-bit index picks one register per channel
// - Read strobe low drives selected register out
// - Write strobe low stores bus byte
// - Transfers reach only channels whose select is low
// - Per-channel pins enabled by enable bit, mode zero
// - Global mode: pin 0 combined, 1-3 off
// - Per-channel interrupt pins assert high
// - Combined interrupt level follows polarity bit
// - Strap high forces per-channel pins driven
// - Reset input clears registers and outputs
package quhb_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CHAN = 4;                  // Channels behind the port
  localparam int unsigned CHAN_W   = 2;                  // Bits to number a channel
  localparam int unsigned ADDR_W   = 3;                  // Register index width
  localparam int unsigned DATA_W   = 8;                  // Data bus width
  localparam int unsigned REG_W    = CHAN_W + ADDR_W;    // Flat register index width
  localparam int unsigned NUM_REGS = NUM_CHAN << ADDR_W; // Registers over all channels

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0]   REG_RESET  = 8'h00;    // Register content after reset
  localparam logic [NUM_CHAN-1:0] CHAN_NONE  = 4'h0;     // No channel / no pin driven
  localparam logic [NUM_CHAN-1:0] SEL_IDLE   = 4'hf;     // All selects released (high)
  localparam logic [ADDR_W-1:0]   ADDR_RESET = 3'h0;     // Sampled index after reset

endpackage

//--- design/quhb_host_port.sv
// Host bus port and interrupt routing for a four-channel UART
`timescale 1ns/1ps
`default_nettype none

module quhb_host_port (
  input  wire logic                        clk,                 // 125 MHz system clock
  input  wire logic                        resetn,              // Async reset, active low
  // Host pins, asynchronous to clk
  input  wire logic                        device_reset,        // Reset pin, active high
  input  wire logic [quhb_pkg::ADDR_W-1:0] addr,                // Register index
  input  wire logic [quhb_pkg::DATA_W-1:0] data_in,             // Data bus, pin level
  output var  logic [quhb_pkg::DATA_W-1:0] data_out,            // Data bus, driven value
  output var  logic                        data_oe,             // Data bus enable, high drives
  input  wire logic                        read_strobe_n,       // Read strobe, active low
  input  wire logic                        write_strobe_n,      // Write strobe, active low
  input  wire logic                        chan0_select_n,      // Channel 0 select, active low
  input  wire logic                        chan1_select_n,      // Channel 1 select, active low
  input  wire logic                        chan2_select_n,      // Channel 2 select, active low
  input  wire logic                        chan3_select_n,      // Channel 3 select, active low
  input  wire logic                        irq_force_strap,     // Strap, high forces drive
  // Configuration and events from the channel cores, same clock
  input  wire logic                        chan0_irq_output_enable_bit, // Channel 0 pin enable
  input  wire logic                        chan1_irq_output_enable_bit, // Channel 1 pin enable
  input  wire logic                        chan2_irq_output_enable_bit, // Channel 2 pin enable
  input  wire logic                        chan3_irq_output_enable_bit, // Channel 3 pin enable
  input  wire logic                        global_irq_mode_bit,     // Merge into pin 0
  input  wire logic                        global_irq_polarity_bit, // Combined level high
  input  wire logic                        chan0_event,         // Channel 0 interrupt pending
  input  wire logic                        chan1_event,         // Channel 1 interrupt pending
  input  wire logic                        chan2_event,         // Channel 2 interrupt pending
  input  wire logic                        chan3_event,         // Channel 3 interrupt pending
  // Interrupt pins, tri-state as value and enable
  output var  logic                        chan0_irq,           // Pin 0, also combined_irq
  output var  logic                        chan0_irq_oe,        // Pin 0 enable
  output var  logic                        chan1_irq,           // Pin 1 level
  output var  logic                        chan1_irq_oe,        // Pin 1 enable
  output var  logic                        chan2_irq,           // Pin 2 level
  output var  logic                        chan2_irq_oe,        // Pin 2 enable
  output var  logic                        chan3_irq,           // Pin 3 level
  output var  logic                        chan3_irq_oe         // Pin 3 enable
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                                  rst_s1_q, rst_s2_q;     // Reset pin synchroniser
  logic                                  rd_s1_q, rd_s2_q;       // Read strobe synchroniser
  logic                                  wr_s1_q, wr_s2_q;       // Write strobe synchroniser
  logic                                  strap_s1_q, strap_s2_q; // Strap synchroniser
  logic [quhb_pkg::NUM_CHAN-1:0]         sel_s1_q, sel_s2_q;     // Select synchronisers
  logic [quhb_pkg::ADDR_W-1:0]           addr_s1_q, addr_s2_q;   // Index synchronisers
  logic [quhb_pkg::DATA_W-1:0]           din_s1_q, din_s2_q;     // Data synchronisers
  logic                                  wr_seen_q;              // Write done this strobe
  logic [quhb_pkg::DATA_W-1:0]           regs_q [quhb_pkg::NUM_REGS]; // Register store
  logic [quhb_pkg::DATA_W-1:0]           dout_q;                 // Read data register
  logic                                  doe_q;                  // Bus drive register
  logic [quhb_pkg::NUM_CHAN-1:0]         irq_q, irq_oe_q;        // Interrupt pin registers
  logic [quhb_pkg::CHAN_W-1:0]           chan_idx;               // Lowest selected channel
  logic                                  any_sel;                // Some select is low
  logic                                  rd_act, wr_go;          // Qualified strobes
  logic [quhb_pkg::REG_W-1:0]            reg_idx;                // Flat register index
  logic [quhb_pkg::NUM_CHAN-1:0]         ev, oe_bit;             // Gathered channel inputs
  logic                                  ev_any;                 // Any channel pending

  assign ev     = {chan3_event, chan2_event, chan1_event, chan0_event};
  assign oe_bit = {chan3_irq_output_enable_bit, chan2_irq_output_enable_bit,
                   chan1_irq_output_enable_bit, chan0_irq_output_enable_bit};
  assign ev_any = |ev;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Two stages on every host pin; the bus is asynchronous to clk.
  // Address and data are stable while a strobe is low, so per-bit
  // synchronising gives a coherent word by the time it is used.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q   <= 1'b0;
      rst_s2_q   <= 1'b0;
      rd_s1_q    <= 1'b1;
      rd_s2_q    <= 1'b1;
      wr_s1_q    <= 1'b1;
      wr_s2_q    <= 1'b1;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      sel_s1_q   <= quhb_pkg::SEL_IDLE;
      sel_s2_q   <= quhb_pkg::SEL_IDLE;
      addr_s1_q  <= quhb_pkg::ADDR_RESET;
      addr_s2_q  <= quhb_pkg::ADDR_RESET;
      din_s1_q   <= quhb_pkg::REG_RESET;
      din_s2_q   <= quhb_pkg::REG_RESET;
    end else begin
      rst_s1_q   <= device_reset;
      rst_s2_q   <= rst_s1_q;
      rd_s1_q    <= read_strobe_n;
      rd_s2_q    <= rd_s1_q;
      wr_s1_q    <= write_strobe_n;
      wr_s2_q    <= wr_s1_q;
      strap_s1_q <= irq_force_strap;
      strap_s2_q <= strap_s1_q;
      sel_s1_q   <= {chan3_select_n, chan2_select_n, chan1_select_n, chan0_select_n};
      sel_s2_q   <= sel_s1_q;
      addr_s1_q  <= addr;
      addr_s2_q  <= addr_s1_q;
      din_s1_q   <= data_in;
      din_s2_q   <= din_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Channel decode
  // ---------------------------------------------------------------
  // Lowest selected channel wins if the host selects several at once;
  // the host should never do that, but the result stays defined.
  always_comb begin
    chan_idx = '0;
    for (int i = quhb_pkg::NUM_CHAN - 1; i >= 0; i--) begin
      if (!sel_s2_q[i]) begin
        chan_idx = i[quhb_pkg::CHAN_W-1:0];
      end
    end
  end

  assign any_sel = ~&sel_s2_q;
  assign reg_idx = {chan_idx, addr_s2_q};
  assign rd_act  = any_sel & ~rd_s2_q;
  assign wr_go   = any_sel & ~wr_s2_q & ~wr_seen_q;

  // ---------------------------------------------------------------
  // Write side
  // ---------------------------------------------------------------
  // One store per strobe low period, so a long strobe does not
  // repeat side effects the channel cores may attach to a write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_seen_q <= 1'b0;
    end else if (rst_s2_q) begin
      wr_seen_q <= 1'b0;
    end else begin
      wr_seen_q <= any_sel & ~wr_s2_q;
    end
  end

  // Register store, cleared by either reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int r = 0; r < quhb_pkg::NUM_REGS; r++) begin
        regs_q[r] <= quhb_pkg::REG_RESET;
      end
    end else if (rst_s2_q) begin
      for (int r = 0; r < quhb_pkg::NUM_REGS; r++) begin
        regs_q[r] <= quhb_pkg::REG_RESET;
      end
    end else if (wr_go) begin
      regs_q[reg_idx] <= din_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Read side
  // ---------------------------------------------------------------
  // Bus is driven only while select and read are both seen low; the
  // synchronisers add two to three cycles of turn-on and turn-off lag,
  // which the host must allow for in its strobe timing.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dout_q <= quhb_pkg::REG_RESET;
      doe_q  <= 1'b0;
    end else if (rst_s2_q) begin
      dout_q <= quhb_pkg::REG_RESET;
      doe_q  <= 1'b0;
    end else begin
      dout_q <= rd_act ? regs_q[reg_idx] : quhb_pkg::REG_RESET;
      doe_q  <= rd_act;
    end
  end

  assign data_out = dout_q;
  assign data_oe  = doe_q;

  // ---------------------------------------------------------------
  // Interrupt routing
  // ---------------------------------------------------------------
  // Global mode: pin 0 always driven with the merged request at the
  // chosen polarity, pins 1-3 released. Otherwise each pin is active
  // high and driven when its enable bit is set or the strap forces it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_q    <= quhb_pkg::CHAN_NONE;
      irq_oe_q <= quhb_pkg::CHAN_NONE;
    end else if (rst_s2_q) begin
      irq_q    <= quhb_pkg::CHAN_NONE;
      irq_oe_q <= quhb_pkg::CHAN_NONE;
    end else if (global_irq_mode_bit) begin
      irq_q    <= {3'h0, ~(ev_any ^ global_irq_polarity_bit)};
      irq_oe_q <= {3'h0, 1'b1};
    end else begin
      irq_q    <= ev;
      irq_oe_q <= oe_bit | {quhb_pkg::NUM_CHAN{strap_s2_q}};
    end
  end

  assign chan0_irq    = irq_q[0];
  assign chan0_irq_oe = irq_oe_q[0];
  assign chan1_irq    = irq_q[1];
  assign chan1_irq_oe = irq_oe_q[1];
  assign chan2_irq    = irq_q[2];
  assign chan2_irq_oe = irq_oe_q[2];
  assign chan3_irq    = irq_q[3];
  assign chan3_irq_oe = irq_oe_q[3];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // The disable clause sees the current reset value, but the edge at
  // which the reset pin is released still runs the clear branch, so
  // each next-cycle check but a_bus_release, a_select_gate and a_reset_clear also asks for reset released at its start.
  a_read_drive_on: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rst_s2_q && rd_act |=> doe_q ##0 $past(any_sel) ##0 !$past(rd_s2_q))
    else $error("bus not driven during read");

  a_bus_release: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rd_act |=> !doe_q)
    else $error("bus driven outside read");

  a_read_data: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rst_s2_q && rd_act && !wr_go |=> dout_q == regs_q[$past(reg_idx)])
    else $error("wrong read data");

  a_write_store: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rst_s2_q && wr_go |=> regs_q[$past(reg_idx)] == $past(din_s2_q) ##1 !wr_go)
    else $error("write not stored once");

  a_select_gate: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    &sel_s2_q |-> !wr_go ##1 !doe_q)
    else $error("transfer without select");

  a_chan_mode: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rst_s2_q && !global_irq_mode_bit && !strap_s2_q |=> irq_oe_q == $past(oe_bit) && irq_q == $past(ev))
    else $error("per-channel pins wrong");

  a_global_mute: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rst_s2_q && global_irq_mode_bit |=> irq_oe_q == 4'h1 && irq_q[3:1] == 3'h0)
    else $error("pins 1-3 active in global mode");

  a_global_level: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rst_s2_q && global_irq_mode_bit && global_irq_polarity_bit |=> irq_q[0] == $past(ev_any))
    else $error("combined level wrong, high polarity");

  a_global_low: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rst_s2_q && global_irq_mode_bit && !global_irq_polarity_bit |=> irq_q[0] == !$past(ev_any))
    else $error("combined level wrong, low polarity");

  a_strap_force: assert property (
    @(posedge clk) disable iff (!resetn || rst_s2_q)
    !rst_s2_q && strap_s2_q && !global_irq_mode_bit |=> irq_oe_q == 4'hf)
    else $error("strap did not force pins");

  a_reset_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    rst_s2_q |=> !doe_q && irq_oe_q == 4'h0 && irq_q == 4'h0 && regs_q[0] == 8'h00)
    else $error("reset did not clear");

endmodule

`default_nettype wire

//--- bench/quhb_host_model.sv
// Behavioural host CPU that drives the strobe bus of the port
`timescale 1ns/1ps
`default_nettype none

module quhb_host_model (
  input  wire logic       clk,            // System clock
  input  wire logic       data_oe,        // Port drives the bus
  input  wire logic [7:0] data_out,       // Value the port drives
  output var  logic [2:0] addr,           // Register index
  output wire logic [7:0] data_in,        // Resolved bus level
  output var  logic       read_strobe_n,  // Read strobe
  output var  logic       write_strobe_n, // Write strobe
  output var  logic [3:0] select_n        // Channel selects
);
  logic       drive_q; // Host owns the bus
  logic [7:0] wdata_q; // Byte the host presents
  logic [7:0] float_q; // Floating bus: never a stale value

  // Nobody drives: show the inverse of the last level
  assign data_in = drive_q ? wdata_q : (data_oe ? data_out : float_q);

  // Flip the floating level every cycle
  always @(negedge clk) begin
    float_q <= ~data_in;
  end

  // Idle bus at time zero
  initial begin
    drive_q = 1'b0;
    wdata_q = 8'h00;
    float_q = 8'h5a;
    addr = 3'h0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    select_n = 4'hf;
  end

  // One transfer; read held until answered or 8 cycles, write held 4 cycles, then idle 4 cycles
  task automatic xfer(input logic rd, input logic [3:0] sel, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    addr = a;
    select_n = sel;
    wdata_q = d;
    drive_q = !rd;
    if (rd) begin
      read_strobe_n = 1'b0;
    end else begin
      write_strobe_n = 1'b0;
    end
    // Write held 4 cycles; read until driven, bounded
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rd ? (data_oe !== 1'b1 && n < 8) : n < 4);
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    select_n = 4'hf;
    drive_q = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the quad UART host port
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       clk, resetn, device_reset, strap, mode, pol;
  logic [3:0] en, ev, sel_n, irq, irq_oe, e_oe, e_v;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, seed, s2;
  logic       data_oe, rd_n, wr_n, oe_q;
  logic [7:0] mem [32];      // Expected register contents
  logic [7:0] exp_q [$];     // Pending read results
  int         fail_count, total_checks, i;

  // ------------------------------------------------------------
  // Device and host
  // ------------------------------------------------------------
  quhb_host_port u_quhb_host_port (.clk(clk), .resetn(resetn), .device_reset(device_reset),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chan0_select_n(sel_n[0]),
    .chan1_select_n(sel_n[1]), .chan2_select_n(sel_n[2]), .chan3_select_n(sel_n[3]),
    .irq_force_strap(strap), .chan0_irq_output_enable_bit(en[0]),
    .chan1_irq_output_enable_bit(en[1]), .chan2_irq_output_enable_bit(en[2]),
    .chan3_irq_output_enable_bit(en[3]), .global_irq_mode_bit(mode),
    .global_irq_polarity_bit(pol), .chan0_event(ev[0]), .chan1_event(ev[1]),
    .chan2_event(ev[2]), .chan3_event(ev[3]), .chan0_irq(irq[0]), .chan0_irq_oe(irq_oe[0]),
    .chan1_irq(irq[1]), .chan1_irq_oe(irq_oe[1]), .chan2_irq(irq[2]),
    .chan2_irq_oe(irq_oe[2]), .chan3_irq(irq[3]), .chan3_irq_oe(irq_oe[3]));
  quhb_host_model u_host (.clk(clk), .data_oe(data_oe), .data_out(data_out), .addr(addr),
    .data_in(data_in), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .select_n(sel_n));

  // Pseudo-random bytes, fixed start so runs repeat
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Single comparison point
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Read one register; expectation queued before the request
  task automatic rd(input logic [1:0] c, input logic [2:0] a);
    exp_q.push_back(mem[{c, a}]);
    u_host.xfer(1'b1, ~(4'h1 << c), a, 8'h00);
    check(data_oe, 1'b0);
  endtask

  // Write one register and note it in the model
  task automatic wr(input logic [1:0] c, input logic [2:0] a, input logic [7:0] d);
    mem[{c, a}] = d;
    u_host.xfer(1'b0, ~(4'h1 << c), a, d);
  endtask

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Monitor: each new drive of the bus answers the oldest read
  always @(negedge clk) begin
    if (data_oe === 1'b1 && !oe_q) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("BAD %0t bus driven with no read pending", $time);
      end else check(data_out, exp_q.pop_front());
    end
    oe_q <= (data_oe === 1'b1);
  end

  // Hang guard, far beyond the expected 780 cycles
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {resetn, device_reset, strap, mode, pol, en, ev} = '0;
    seed = 8'h19;
    for (i = 0; i < 32; i++) mem[i] = 8'h00;
    repeat (20) @(negedge clk);
    check({irq_oe, 3'h0, data_oe}, 8'h00);
    check({irq, irq_oe}, 8'h00);
    check(data_out, 8'h00);
    resetn = 1'b1;
    rd(2'h3, 3'h7);
    // Fill every register of every channel, then read all back
    for (i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      wr(i[4:3], i[2:0], seed);
    end
    for (i = 0; i < 32; i++) rd(i[4:3], i[2:0]);
    // Unselected write is dropped and unselected read never drives
    u_host.xfer(1'b0, 4'hf, 3'h2, ~mem[2]);
    u_host.xfer(1'b1, 4'hf, 3'h2, 8'h00);
    check(data_oe, 1'b0);
    rd(2'h0, 3'h2);
    // Interrupt routing over random modes, straps and events
    for (i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      s2 = lfsr(seed ^ 8'h3c);
      {ev, en} = seed;
      {strap, pol, mode} = s2[2:0];
      repeat (4) @(negedge clk);
      e_oe = mode ? 4'h1 : (en | {4{strap}});
      e_v = mode ? {3'h0, (|ev) ? pol : ~pol} : ev;
      check(irq_oe, e_oe);
      check(irq, e_v);
    end
    // Reset pin clears pins and registers
    mode = 1'b1;
    device_reset = 1'b1;
    repeat (5) @(negedge clk);
    check({irq_oe, 3'h0, data_oe}, 8'h00);
    check({irq, irq_oe}, 8'h00);
    check(data_out, 8'h00);
    device_reset = 1'b0;
    for (i = 0; i < 32; i++) mem[i] = 8'h00;
    repeat (5) @(negedge clk);
    rd(2'h2, 3'h5);
    check(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
